/* File: design/lbp_i2c_slave.sv */
// Byte-register serial slave: device address, register pointer, write and read bytes.
// Assumes scl and sda arrive synchronous to ref_clk and far slower than it.
`timescale 1ns/1ns
`default_nettype none
module lbp_i2c_slave
  import lbp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe,
  output logic wr_stb,
  output logic [7:0] reg_ptr,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  lbp_i2c_t state_ff;
  logic scl_q_ff;
  logic sda_q_ff;
  logic ack_ff;
  logic full_ff;
  logic [2:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] ptr_ff;
  logic oe_ff;
  logic stb_ff;
  wire scl_rise = scl_i & ~scl_q_ff;
  wire scl_fall = ~scl_i & scl_q_ff;
  wire start_det = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  wire stop_det = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
  wire rx_state = (state_ff == LBP_I2C_DEV) || (state_ff == LBP_I2C_REG) ||
                  (state_ff == LBP_I2C_WR);

  assign sda_oe = oe_ff;
  assign wr_stb = stb_ff;
  assign reg_ptr = ptr_ff;
  assign wr_data = shift_ff;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= LBP_I2C_IDLE;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      ack_ff <= 1'b0;
      full_ff <= 1'b0;
      cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      oe_ff <= 1'b0;
      stb_ff <= 1'b0;
    end
    else
    begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
      stb_ff <= 1'b0;
      if (start_det)
      begin
        state_ff <= LBP_I2C_DEV;
        cnt_ff <= 3'h0;
        ack_ff <= 1'b0;
        full_ff <= 1'b0;
        oe_ff <= 1'b0;
      end
      else if (stop_det)
      begin
        state_ff <= LBP_I2C_IDLE;
        oe_ff <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (rx_state && !ack_ff)
        begin
          shift_ff <= {shift_ff[6:0], sda_i};
          cnt_ff <= cnt_ff + 3'h1;
          full_ff <= (cnt_ff == 3'h7);
        end
        else if (state_ff == LBP_I2C_RD && ack_ff && sda_i)
          state_ff <= LBP_I2C_IDLE;
      end
      else if (scl_fall)
      begin
        if (ack_ff)
        begin
          // End of an acknowledge bit; a read then puts out the addressed byte's msb.
          ack_ff <= 1'b0;
          oe_ff <= (state_ff == LBP_I2C_RD) && !rd_data[7];
          shift_ff <= {rd_data[6:0], 1'b0};
          cnt_ff <= 3'h1;
          if (state_ff != LBP_I2C_RD)
            cnt_ff <= 3'h0;
        end
        else if (full_ff)
        begin
          full_ff <= 1'b0;
          ack_ff <= 1'b1;
          oe_ff <= 1'b1;
          if (state_ff == LBP_I2C_DEV)
          begin
            if (shift_ff[7:1] == DEV_ADDR)
              state_ff <= shift_ff[0] ? LBP_I2C_RD : LBP_I2C_REG;
            else
            begin
              state_ff <= LBP_I2C_IDLE;
              ack_ff <= 1'b0;
              oe_ff <= 1'b0;
            end
          end
          else if (state_ff == LBP_I2C_REG)
          begin
            ptr_ff <= shift_ff;
            state_ff <= LBP_I2C_WR;
          end
          else
          begin
            stb_ff <= 1'b1;
          end
        end
        else if (state_ff == LBP_I2C_WR && cnt_ff == 3'h0 && stb_ff == 1'b0)
          oe_ff <= 1'b0;
        else if (state_ff == LBP_I2C_RD)
        begin
          if (cnt_ff == 3'h0)
          begin
            // Byte sent: release sda for the master's acknowledge.
            oe_ff <= 1'b0;
            ack_ff <= 1'b1;
            ptr_ff <= ptr_ff + 8'h01;
          end
          else
          begin
            oe_ff <= !shift_ff[7];
            shift_ff <= {shift_ff[6:0], 1'b0};
            cnt_ff <= cnt_ff + 3'h1;
          end
        end
      end
      if (stb_ff)
        ptr_ff <= ptr_ff + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: design/lbp_pkg.sv */
// Package for the LED boost controller: register map, field positions, timing counts.
// Assumes a single 10 MHz clock and byte-wide register addresses on the serial port.
//
// How it works
// (RQ1) The power switch closes whenever the feedback comparator says feedback is below reference.
// (RQ2) The power switch opens on a peak current trip or after the maximum on-time of 6 us.
// (RQ3) Once open, the switch stays open until feedback is below reference again.
// (RQ4) Low duty bits 7..0 weigh 6.25% down to 0.048% of the period, adding only when set.
// (RQ5) The period has 2048 steps; duty is three config bits (50/25/12.5%) above the low byte.
// (RQ6) The LED switch gets one pulse per period at a fixed rate, apart from boost switching.
// (RQ7) Repetition bits 00/01/10/11 select 550/366/275/220 Hz.
// (RQ8) The current limit bit selects 300 mA when clear and 500 mA when set.
// (RQ9) Start-up uses a quarter limit for 256 switch cycles, a half for 256 more, then full.
// (RQ10) Soft-start disable (config bit 7) clear steps the start-up, set gives full limit at once.
// (RQ11) The converter is enabled while the 11-bit duty is nonzero and disabled while it is zero.
// (RQ12) An overvoltage trip holds the power switch open until the hysteretic comparator releases.
// (RQ13) Both switches are open in sleep mode and while the converter is off.
// (RQ14) Gain bit (config bit 3) leaves the open-drain gain pin floating when clear, low when set.
// (RQ15) The LED switch closes at period start and stays closed while the step is below duty.
package lbp_pkg;
  localparam logic [7:0] LBP_ADDR_DUTY_LOW = 8'h57;
  localparam logic [7:0] LBP_ADDR_CONFIG = 8'h58;
  localparam logic [7:0] LBP_DUTY_LOW_RST = 8'h00;
  localparam logic [7:0] LBP_CONFIG_RST = 8'h00;
  localparam int LBP_CFG_SOFT_OFF = 7;
  localparam int LBP_CFG_ILIM = 6;
  localparam int LBP_CFG_REP_HI = 5;
  localparam int LBP_CFG_REP_LO = 4;
  localparam int LBP_CFG_GAIN = 3;
  localparam int LBP_CFG_DUTY_HI = 2;
  localparam int LBP_CLK_HZ = 10000000;
  localparam int LBP_CLK_NS = 100;
  localparam int LBP_MAX_ON_NS = 6000;
  // A longest time rounds down to whole cycles.
  localparam int LBP_MAX_ON_CYC = LBP_MAX_ON_NS / LBP_CLK_NS;
  localparam int LBP_STEPS = 2048;
  localparam int LBP_SS_CYCLES = 256;
  localparam int LBP_RATE0_HZ = 550;
  localparam int LBP_RATE1_HZ = 366;
  localparam int LBP_RATE2_HZ = 275;
  localparam int LBP_RATE3_HZ = 220;
  // Clocks per PWM step, rounded to nearest; the real rate is within about 3% of nominal.
  localparam int LBP_DIV0 = (LBP_CLK_HZ + LBP_RATE0_HZ * LBP_STEPS / 2) / (LBP_RATE0_HZ * LBP_STEPS);
  localparam int LBP_DIV1 = (LBP_CLK_HZ + LBP_RATE1_HZ * LBP_STEPS / 2) / (LBP_RATE1_HZ * LBP_STEPS);
  localparam int LBP_DIV2 = (LBP_CLK_HZ + LBP_RATE2_HZ * LBP_STEPS / 2) / (LBP_RATE2_HZ * LBP_STEPS);
  localparam int LBP_DIV3 = (LBP_CLK_HZ + LBP_RATE3_HZ * LBP_STEPS / 2) / (LBP_RATE3_HZ * LBP_STEPS);
  localparam logic [1:0] LBP_SCALE_QUARTER = 2'h0;
  localparam logic [1:0] LBP_SCALE_HALF = 2'h1;
  localparam logic [1:0] LBP_SCALE_FULL = 2'h2;
  typedef enum logic [1:0] {LBP_SS_Q, LBP_SS_H, LBP_SS_F} lbp_ss_t;
  typedef enum logic [2:0] {LBP_I2C_IDLE, LBP_I2C_DEV, LBP_I2C_REG, LBP_I2C_WR, LBP_I2C_RD} lbp_i2c_t;
endpackage

/* File: design/lbp_top.sv */
// LED boost control: peak-current pulse-frequency switch control, soft start, LED PWM, gain pin.
// Assumes comparator outputs are clean logic levels synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module lbp_top
  import lbp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  parameter int STEPS = LBP_STEPS
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe,
  input wire logic fb_below_ref,
  input wire logic peak_trip,
  input wire logic ovp_trip,
  input wire logic sleep_mode,
  output logic power_switch_on,
  output logic led_switch_on,
  output logic current_limit_select,
  output logic [1:0] limit_scale,
  output logic gain_select_pin_out,
  output logic gain_select_pin_oe
);
  localparam int DW = $clog2(STEPS);

  logic [7:0] duty_low_ff;
  logic [7:0] config_ff;
  logic wr_stb;
  logic [7:0] reg_ptr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic i2c_oe;
  logic sw_on_ff;
  logic [5:0] ontime_ff;
  logic [4:0] presc_ff;
  logic [DW-1:0] step_ff;
  logic led_on_ff;
  lbp_ss_t ss_ff;
  logic [7:0] ss_cnt_ff;
  logic [1:0] scale_ff;
  logic ilim_ff;
  logic gain_oe_ff;

  lbp_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_i2c (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe(i2c_oe),
    .wr_stb(wr_stb),
    .reg_ptr(reg_ptr),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  // Register decode; unmapped pointers read as zero and ignore writes.
  wire sel_duty = (reg_ptr == LBP_ADDR_DUTY_LOW);
  wire sel_cfg = (reg_ptr == LBP_ADDR_CONFIG);
  assign rd_data = sel_duty ? duty_low_ff : (sel_cfg ? config_ff : 8'h00);

  // Bits 7..0 of the low byte carry weights 128..1 of 2048 steps: 6.25% down to 0.048%. (see RQ4)
  wire [10:0] duty = {config_ff[LBP_CFG_DUTY_HI:0], duty_low_ff}; // (see RQ5)
  wire conv_en = (duty != 11'h000); // (see RQ11)
  wire run = conv_en && !sleep_mode; // (see RQ13)
  wire ontime_last = (ontime_ff == 6'(LBP_MAX_ON_CYC - 1));
  wire open_req = peak_trip || ontime_last;
  wire nxt_sw_on = !run || ovp_trip ? 1'b0 : (sw_on_ff ? !open_req : fb_below_ref);
  wire sw_cycle_done = sw_on_ff && !nxt_sw_on;

  wire [1:0] rep_sel = {config_ff[LBP_CFG_REP_HI], config_ff[LBP_CFG_REP_LO]};
  wire [4:0] presc_top = (rep_sel == 2'h0) ? 5'(LBP_DIV0 - 1) :
                         (rep_sel == 2'h1) ? 5'(LBP_DIV1 - 1) :
                         (rep_sel == 2'h2) ? 5'(LBP_DIV2 - 1) : 5'(LBP_DIV3 - 1); // (see RQ7)
  wire step_en = (presc_ff == presc_top);
  wire [DW-1:0] nxt_step = step_en ? step_ff + DW'(1) : step_ff;
  wire nxt_led_on = run && ({1'b0, nxt_step} < {1'b0, duty});

  wire ss_last = (ss_cnt_ff == 8'(LBP_SS_CYCLES - 1));
  wire [1:0] nxt_scale = config_ff[LBP_CFG_SOFT_OFF] ? LBP_SCALE_FULL :
                         (ss_ff == LBP_SS_Q) ? LBP_SCALE_QUARTER :
                         (ss_ff == LBP_SS_H) ? LBP_SCALE_HALF : LBP_SCALE_FULL; // (see RQ10)

  assign sda_oe = i2c_oe;
  assign power_switch_on = sw_on_ff;
  assign led_switch_on = led_on_ff;
  assign current_limit_select = ilim_ff;
  assign limit_scale = scale_ff;
  assign gain_select_pin_out = 1'b0;
  assign gain_select_pin_oe = gain_oe_ff;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      duty_low_ff <= LBP_DUTY_LOW_RST;
      config_ff <= LBP_CONFIG_RST;
    end
    else if (wr_stb && sel_duty)
      duty_low_ff <= wr_data;
    else if (wr_stb && sel_cfg)
      config_ff <= wr_data;
  end

  // Power switch: close on low feedback, open on peak current or max on-time. (see RQ1)
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sw_on_ff <= 1'b0;
      ontime_ff <= 6'h00;
    end
    else
    begin
      sw_on_ff <= nxt_sw_on; // (see RQ2) (see RQ3) (see RQ12)
      ontime_ff <= nxt_sw_on && sw_on_ff ? ontime_ff + 6'h01 : 6'h00;
    end
  end

  // The LED timebase runs free of the boost switch so brightness depends on duty alone. (see RQ6)
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      presc_ff <= 5'h00;
      step_ff <= '0;
      led_on_ff <= 1'b0;
    end
    else
    begin
      presc_ff <= step_en ? 5'h00 : presc_ff + 5'h01;
      step_ff <= nxt_step;
      led_on_ff <= nxt_led_on; // (see RQ15)
    end
  end

  // Soft start restarts every time the converter is turned off, so each enable ramps again.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ss_ff <= LBP_SS_Q;
      ss_cnt_ff <= 8'h00;
      scale_ff <= LBP_SCALE_QUARTER;
      ilim_ff <= 1'b0;
      gain_oe_ff <= 1'b0;
    end
    else
    begin
      ilim_ff <= config_ff[LBP_CFG_ILIM]; // (see RQ8)
      gain_oe_ff <= config_ff[LBP_CFG_GAIN]; // (see RQ14)
      scale_ff <= nxt_scale;
      if (!run)
      begin
        ss_ff <= LBP_SS_Q;
        ss_cnt_ff <= 8'h00;
      end
      else if (sw_cycle_done && ss_ff != LBP_SS_F)
      begin
        ss_cnt_ff <= ss_cnt_ff + 8'h01; // (see RQ9)
        if (ss_last)
        begin
          case (ss_ff)
            LBP_SS_Q: ss_ff <= LBP_SS_H;
            default: ss_ff <= LBP_SS_F;
          endcase
        end
      end
    end
  end

  // Independent tallies for the checks below, so a broken counter cannot vouch for itself.
  logic [9:0] hlp_falls_ff;
  logic [6:0] hlp_on_ff;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hlp_falls_ff <= 10'h000;
      hlp_on_ff <= 7'h00;
    end
    else
    begin
      if (!run)
        hlp_falls_ff <= 10'h000;
      else if (sw_cycle_done && !hlp_falls_ff[9])
        hlp_falls_ff <= hlp_falls_ff + 10'h001;
      if (!sw_on_ff)
        hlp_on_ff <= 7'h00;
      else if (!hlp_on_ff[6])
        hlp_on_ff <= hlp_on_ff + 7'h01;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_closed_long;
    sw_on_ff [*8];
  endsequence

  sequence s_stage_end;
    run && sw_cycle_done && ss_last;
  endsequence

  chk_fb_closes: assert property (run && !ovp_trip && !sw_on_ff && fb_below_ref |=> sw_on_ff) // see RQ1
    else $error("switch did not close on low feedback");
  chk_peak_opens: assert property (sw_on_ff && peak_trip |=> !sw_on_ff) // see RQ2
    else $error("switch did not open on peak trip");
  chk_max_ontime: assert property (ontime_ff <= 6'(LBP_MAX_ON_CYC - 1)) // see RQ2
    else $error("on-time exceeded limit");
  chk_stay_open: assert property (!sw_on_ff && !fb_below_ref |=> !sw_on_ff) // see RQ3
    else $error("switch closed without low feedback");
  chk_ovp_hold: assert property (ovp_trip |=> !sw_on_ff) // see RQ12
    else $error("switch closed during overvoltage");
  chk_off_open: assert property (!run |=> !sw_on_ff && !led_on_ff) // see RQ13
    else $error("switch closed while off or asleep");
  chk_led_duty: assert property (step_en && run |=> // see RQ15
                                 led_on_ff == ({1'b0, step_ff} < {1'b0, $past(duty)}))
    else $error("led switch disagrees with duty");
  chk_soft_disable: assert property (config_ff[LBP_CFG_SOFT_OFF] |=> scale_ff == LBP_SCALE_FULL)
    // see RQ10
    else $error("soft start not bypassed");
  chk_ss_start: assert property ($rose(run) && !config_ff[LBP_CFG_SOFT_OFF] ##1
                                 !config_ff[LBP_CFG_SOFT_OFF] |-> scale_ff == LBP_SCALE_QUARTER)
    // see RQ9
    else $error("start-up did not begin at quarter limit");
  chk_gain_pin: assert property (##1 gain_select_pin_oe == $past(config_ff[LBP_CFG_GAIN])) // see RQ14
    else $error("gain pin not following its bit");
  chk_max_run: assert property (s_closed_long |-> ontime_ff >= 6'h07) // see RQ2
    else $error("on-time counter not counting");

  chk_duty_write: assert property ( // see RQ4
    wr_stb && sel_duty |=> duty_low_ff == $past(wr_data))
    else $error("low duty byte write lost");

  chk_cfg_write: assert property ( // see RQ5
    wr_stb && sel_cfg |=> config_ff == $past(wr_data))
    else $error("config write lost");

  chk_regs_hold: assert property ( // see RQ5
    !(wr_stb && (sel_duty || sel_cfg)) |=> $stable(duty_low_ff) && $stable(config_ff))
    else $error("register changed without a write");

  chk_close_cause: assert property ( // see RQ3
    $rose(sw_on_ff) |-> $past(fb_below_ref) && $past(run) && !$past(ovp_trip))
    else $error("switch closed without low feedback");

  chk_ontime_step: assert property ( // see RQ2
    sw_on_ff ##1 sw_on_ff |-> ontime_ff == 6'($past(ontime_ff) + 6'h01))
    else $error("on-time count skipped");

  chk_ontime_clear: assert property ( // see RQ2
    !sw_on_ff |-> ontime_ff == 6'h00)
    else $error("on-time count not cleared");

  chk_ontime_open: assert property ( // see RQ2
    sw_on_ff && ontime_ff == 6'(LBP_MAX_ON_CYC - 1) |=> !sw_on_ff)
    else $error("switch held past on-time");

  chk_on_limit: assert property ( // see RQ2
    sw_on_ff |-> hlp_on_ff < 7'(LBP_MAX_ON_CYC))
    else $error("switch closed too long");

  chk_duty_zero: assert property ( // see RQ11
    duty == 11'h000 |=> !sw_on_ff && !led_on_ff)
    else $error("switch closed with zero duty");

  chk_sleep_open: assert property ( // see RQ13
    sleep_mode |=> !sw_on_ff && !led_on_ff)
    else $error("switch closed in sleep");

  chk_step_advance: assert property ( // see RQ5
    step_en |=> step_ff == DW'($past(step_ff) + DW'(1)))
    else $error("step did not advance");

  chk_step_hold: assert property ( // see RQ6
    !step_en |=> $stable(step_ff))
    else $error("step moved off its tick");

  chk_led_start: assert property ( // see RQ15
    run && step_en && step_ff == {DW{1'b1}} && duty != 11'h000 |=> led_on_ff)
    else $error("led switch not closed at period start");

  chk_ilim_follow: assert property ( // see RQ8
    ##1 current_limit_select == $past(config_ff[LBP_CFG_ILIM]))
    else $error("current limit not following its bit");

  chk_ss_reset: assert property ( // see RQ9
    !run |=> ss_ff == LBP_SS_Q)
    else $error("soft start not restarted");

  chk_ss_quarter: assert property ( // see RQ9
    run && hlp_falls_ff < 10'(LBP_SS_CYCLES) |-> ss_ff == LBP_SS_Q)
    else $error("quarter stage left early");

  chk_ss_half: assert property ( // see RQ9
    run && hlp_falls_ff >= 10'(LBP_SS_CYCLES) && hlp_falls_ff < 10'(2 * LBP_SS_CYCLES) |->
    ss_ff == LBP_SS_H)
    else $error("half stage out of place");

  chk_ss_full: assert property ( // see RQ9
    run && hlp_falls_ff == 10'(2 * LBP_SS_CYCLES) |-> ss_ff == LBP_SS_F)
    else $error("full stage not reached");

  chk_q_to_h: assert property ( // see RQ9
    ss_ff == LBP_SS_Q ##0 s_stage_end |=> ss_ff == LBP_SS_H)
    else $error("quarter stage did not end");

  chk_h_to_f: assert property ( // see RQ9
    ss_ff == LBP_SS_H ##0 s_stage_end |=> ss_ff == LBP_SS_F)
    else $error("half stage did not end");

  chk_scale_half: assert property ( // see RQ9
    !config_ff[LBP_CFG_SOFT_OFF] && ss_ff == LBP_SS_H |=> scale_ff == LBP_SCALE_HALF)
    else $error("half limit not applied");

  chk_scale_full: assert property ( // see RQ9
    ss_ff == LBP_SS_F |=> scale_ff == LBP_SCALE_FULL)
    else $error("full limit not applied");
endmodule
`default_nettype wire

/* File: tb/lbp_load_model.sv */
// Load model: inductor ramp and LED feedback seen by the comparators.
// Assumes the switch level is sampled on ref_clk; times are clock counts.
`timescale 1ns/1ns
`default_nettype none
module lbp_load_model
#(
  parameter int DECAY = 4
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic power_switch_on,
  input wire logic [7:0] ramp_cycles,
  output logic fb_below_ref,
  output logic peak_trip
);
  logic [7:0] age_ff;
  logic last_ff;
  // A slow ramp never trips the peak, so only the on-time limit can open the switch.
  assign peak_trip = power_switch_on && last_ff && (age_ff >= ramp_cycles);
  assign fb_below_ref = !power_switch_on && !last_ff && (age_ff >= 8'(DECAY));
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      age_ff <= 8'h00;
      last_ff <= 1'b0;
    end
    else
    begin
      last_ff <= power_switch_on;
      age_ff <= (last_ff != power_switch_on) ? 8'h00 : age_ff + 8'(age_ff != 8'hff);
    end
  end
endmodule
`default_nettype wire

/* File: tb/lbp_top_test.sv */
// Bench for the LED boost control: registers, switch control, soft start, LED PWM.
// Assumes the load model closes the loop from the power switch to the comparators.
`timescale 1ns/1ns
`default_nettype none
module lbp_top_test;
  import lbp_pkg::*;
  localparam int STEPS = 256;
  localparam logic [6:0] ADDR = 7'h2a;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic scl = 1'b1;
  logic sda_drv = 1'b1;
  logic ovp = 1'b0;
  logic sleep = 1'b0;
  logic [7:0] ramp = 8'h03;
  logic [7:0] rd;
  wire logic sda_oe, fb, peak, psw, led, ilim, gout, goe;
  wire logic [1:0] scale;
  wire logic sda = sda_drv & ~sda_oe;
  int miscompares = 0;
  int num_checks = 0;
  int div[4] = '{LBP_DIV0, LBP_DIV1, LBP_DIV2, LBP_DIV3};
  int hi, per;
  always #50 ref_clk = ~ref_clk;
  lbp_top #(.DEV_ADDR(ADDR), .STEPS(STEPS)) u_lbp_top (.ref_clk(ref_clk), .nrst(nrst),
    .scl_i(scl), .sda_i(sda), .sda_oe(sda_oe), .fb_below_ref(fb), .peak_trip(peak),
    .ovp_trip(ovp), .sleep_mode(sleep), .power_switch_on(psw), .led_switch_on(led),
    .current_limit_select(ilim), .limit_scale(scale), .gain_select_pin_out(gout),
    .gain_select_pin_oe(goe));
  lbp_load_model u_lbp_load_model (.ref_clk(ref_clk), .nrst(nrst), .power_switch_on(psw),
    .ramp_cycles(ramp), .fb_below_ref(fb), .peak_trip(peak));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic put_bit(input logic b);
    sda_drv = b;
    tk(5);
    scl = 1'b1;
    tk(10);
    scl = 1'b0;
    tk(5);
  endtask
  task automatic put_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      put_bit(v[i]);
    sda_drv = 1'b1;
    tk(5);
    scl = 1'b1;
    tk(5);
    check("ack", 16'h1, 16'(sda_oe));
    tk(5);
    scl = 1'b0;
    tk(5);
  endtask
  task automatic bus_start(input logic [7:0] a);
    sda_drv = 1'b1;
    tk(5);
    scl = 1'b1;
    tk(5);
    sda_drv = 1'b0;
    tk(5);
    scl = 1'b0;
    tk(5);
    put_byte({ADDR, 1'b0});
    put_byte(a);
  endtask
  task automatic bus_stop();
    sda_drv = 1'b0;
    tk(5);
    scl = 1'b1;
    tk(5);
    sda_drv = 1'b1;
    tk(10);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    bus_start(a);
    put_byte(d);
    bus_stop();
  endtask
  // Reads clock in a fresh byte after the address, sampling five clocks into the fifteen-clock high.
  task automatic reg_get(input logic [7:0] a, output logic [7:0] v);
    bus_start(a);
    sda_drv = 1'b1;
    tk(5);
    scl = 1'b1;
    tk(5);
    sda_drv = 1'b0;
    tk(5);
    scl = 1'b0;
    tk(5);
    put_byte({ADDR, 1'b1});
    for (int i = 0; i < 8; i++)
    begin
      tk(5);
      scl = 1'b1;
      tk(5);
      v = {v[6:0], sda};
      tk(10);
      scl = 1'b0;
    end
    put_bit(1'b1);
    bus_stop();
  endtask
  task automatic wait_falls(input int n);
    int seen = 0;
    logic prev = psw;
    for (int k = 0; k < 40000 && seen < n; k++)
    begin
      tk(1);
      seen += int'(prev && !psw);
      prev = psw;
    end
    if (seen < n)
    begin
      check("switch cycles", 16'(n), 16'(seen));
      summarize();
    end
  endtask
  task automatic psw_quiet(input string what, input int n);
    int cnt = 0;
    repeat (n)
    begin
      tk(1);
      cnt += int'(psw !== 1'b0);
    end
    check(what, 16'h0, 16'(cnt));
  endtask
  task automatic measure();
    int n = 0;
    logic prev = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      while (led && n < 20000)
      begin
        tk(1);
        n++;
      end
      while (!led && n < 20000)
      begin
        tk(1);
        n++;
      end
    end
    hi = 0;
    per = 0;
    while (!(!prev && led) && per < 20000)
    begin
      prev = led;
      hi += int'(led);
      tk(1);
      per++;
    end
    if (n >= 20000 || per >= 20000)
    begin
      check("pwm timeout", 16'h0, 16'h1);
      summarize();
    end
  endtask
  task automatic test_reset();
    check("idle outputs", 16'h0, 16'({psw, led, scale, goe, gout, sda_oe, ilim}));
    reg_get(LBP_ADDR_CONFIG, rd);
    check("config reset", 16'(LBP_CONFIG_RST), 16'(rd));
    psw_quiet("off while duty zero", 50);
  endtask
  task automatic test_soft_start();
    // Sleep holds the ramp at its start until the write is done, so no cycle goes uncounted.
    sleep = 1'b1;
    reg_wr(LBP_ADDR_DUTY_LOW, 8'h40);
    tk(2);
    sleep = 1'b0;
    wait_falls(LBP_SS_CYCLES - 1);
    check("scale quarter", 16'(LBP_SCALE_QUARTER), 16'(scale));
    wait_falls(1);
    tk(3);
    check("scale half", 16'(LBP_SCALE_HALF), 16'(scale));
    wait_falls(LBP_SS_CYCLES);
    tk(3);
    check("scale full", 16'(LBP_SCALE_FULL), 16'(scale));
  endtask
  task automatic test_switch();
    int n = 0;
    ramp = 8'hc8;
    wait_falls(1);
    while (!psw && n < 100)
    begin
      tk(1);
      n++;
    end
    n = 0;
    while (psw && n < 200)
    begin
      tk(1);
      n++;
    end
    check("on time", 16'(LBP_MAX_ON_CYC), 16'(n));
    ramp = 8'h03;
    wait_falls(3);
    ovp = 1'b1;
    tk(2);
    psw_quiet("over voltage", 40);
    ovp = 1'b0;
    wait_falls(2);
    sleep = 1'b1;
    tk(2);
    psw_quiet("sleep", 40);
    check("led in sleep", 16'h0, 16'(led));
    sleep = 1'b0;
  endtask
  task automatic test_regs();
    reg_wr(LBP_ADDR_DUTY_LOW, 8'h00);
    tk(3);
    psw_quiet("disabled", 40);
    check("led disabled", 16'h0, 16'(led));
    check("scale idle", 16'(LBP_SCALE_QUARTER), 16'(scale));
    reg_wr(LBP_ADDR_CONFIG, 8'h01);
    wait_falls(2);
    reg_wr(LBP_ADDR_CONFIG, 8'hc8);
    reg_wr(LBP_ADDR_DUTY_LOW, 8'h20);
    tk(3);
    check("limit gain", 16'h6, 16'({ilim, goe, gout}));
    check("scale bypass", 16'(LBP_SCALE_FULL), 16'(scale));
    reg_get(LBP_ADDR_CONFIG, rd);
    check("config read", 16'h00c8, 16'(rd));
    reg_get(8'h60, rd);
    check("unmapped read", 16'h0, 16'(rd));
  endtask
  task automatic test_pwm();
    for (int r = 0; r < 4; r++)
    begin
      reg_wr(LBP_ADDR_CONFIG, 8'h80 | 8'(r << 4));
      measure();
      check("period", 16'(STEPS * div[r]), 16'(per));
      check("high", 16'(32 * div[r]), 16'(hi));
    end
    reg_wr(LBP_ADDR_CONFIG, 8'h80);
    for (int b = 0; b < 8; b += 7)
    begin
      reg_wr(LBP_ADDR_DUTY_LOW, 8'h01 << b);
      measure();
      check("bit weight", 16'((1 << b) * div[0]), 16'(hi));
    end
  endtask
  initial
  begin
    tk(16);
    nrst = 1'b1;
    tk(2);
    test_reset();
    test_soft_start();
    test_switch();
    test_regs();
    test_pwm();
    summarize();
  end
endmodule
`default_nettype wire
